// [core/fbpl_core.sv]
// Block protection core: guard bits, freeze flag, password unlock
`timescale 1ns/1ns
module fbpl_core
   import fbpl_pkg::*;
(
   // Clock and resets
   input  wire logic      mclk,
   input  wire logic      rst,
   input  wire logic      nv_init,
   // Register port
   input  wire fbpl_bus_s bus,
   output      logic [31:0] rd_data,
   // Boot guard pin, active low
   input  wire logic      boot_guard_pin_n,
   // Array engine handshake
   output      fbpl_arr_s arr,
   input  wire logic      arr_done,
   // Engine busy
   output      logic      busy
);

   // Current and next state
   fbpl_core_s s;
   fbpl_core_s next_s;

   // Block index from sector address
   function automatic logic [6:0] blk_of(input logic [8:0] a);
      logic [6:0] b;
      b = 7'h00;
      if (a[8:3] == 6'h00) begin
         // Low boot blocks 0 to 7
         b = {4'h0, a[2:0]};
      end else if (a[8:3] == 6'h3F) begin
         // High boot blocks 70 to 77
         b = 7'h46 + {4'h0, a[2:0]};
      end else begin
         // Large blocks 8 to 69, one per sector group
         b = 7'h07 + {1'b0, a[8:3]};
      end
      return b;
   endfunction : blk_of

   // Guard group from sector address
   function automatic logic [5:0] grp_of(input logic [8:0] a);
      logic [5:0] g;
      g = 6'h00;
      if (a[8:3] == 6'h00) begin
         // Low boot blocks, one each
         g = {3'h0, a[2:0]};
      end else if (a[8:3] == 6'h3F) begin
         // High boot blocks, one each
         g = 6'h1C + {3'h0, a[2:0]};
      end else if (a[8:3] < 6'h04) begin
         // Lone large blocks at the low end
         g = 6'h07 + a[8:3];
      end else if (a[8:3] >= 6'h3C) begin
         // Lone large blocks at the high end
         g = a[8:3] - 6'h23;
      end else begin
         // Four large blocks share one bit
         g = 6'h0A + {2'h0, a[8:5]};
      end
      return g;
   endfunction : grp_of

   // Outer two boot blocks at each end
   function automatic logic is_outer(input logic [8:0] a);
      return (a[8:1] == 8'h00) || (a[8:1] == 8'hFF);
   endfunction : is_outer

   // Decoded target and its protection
   logic [6:0] tgt_blk;
   logic [5:0] tgt_grp;
   logic       tgt_prot;
   logic       pin_lock;
   logic       cmd_wr;
   logic [3:0] op;

   // Target decode
   always_comb begin
      tgt_blk  = blk_of(s.target);
      tgt_grp  = grp_of(s.target);
      pin_lock = ~s.wp_sync & is_outer(s.target);
      tgt_prot = s.nv[tgt_grp] | s.vol[tgt_blk] | pin_lock;
      // Command write and its opcode
      cmd_wr   = bus.wr && (bus.addr == REG_CMD);
      op       = bus.wdata[3:0];
   end

   // Next state
   always_comb begin
      next_s = s;
      // One-cycle request toward the array
      next_s.arr.req = 1'b0;
      // Pin synchroniser
      next_s.wp_meta = boot_guard_pin_n;
      // Only the second stage feeds logic
      next_s.wp_sync = s.wp_meta;

      // Operand registers
      // Taken in any state, even while busy
      if (bus.wr && (bus.addr == REG_TARGET)) begin
         next_s.target = bus.wdata[8:0];
      end
      if (bus.wr && (bus.addr == REG_DATA)) begin
         next_s.data = bus.wdata[15:0];
      end

      // Engine
      case (s.st)
         S_IDLE: begin
            if (cmd_wr) begin
               // New command clears last outcome
               next_s.done    = 1'b0;
               next_s.refused = 1'b0;
               case (op)
                  OP_PROG: begin
                     if (tgt_prot) begin
                        next_s.refused = 1'b1;
                        next_s.cnt     = PROG_CNT;
                        next_s.st      = S_POLL;
                     end else begin
                        // Open block goes to the array
                        next_s.arr.req    = 1'b1;
                        next_s.arr.erase  = 1'b0;
                        next_s.arr.sector = s.target;
                        next_s.st         = S_ARRAY;
                     end
                  end
                  OP_ERASE: begin
                     if (tgt_prot) begin
                        next_s.refused = 1'b1;
                        next_s.cnt     = ERASE_CNT;
                        next_s.st      = S_POLL;
                     end else begin
                        // Open block goes to the array
                        next_s.arr.req    = 1'b1;
                        next_s.arr.erase  = 1'b1;
                        next_s.arr.sector = s.target;
                        next_s.st         = S_ARRAY;
                     end
                  end
                  OP_NV_SET: begin
                     next_s.done = 1'b1;
                     if (s.freeze) begin
                        next_s.refused = 1'b1;
                     end else begin
                        next_s.nv[tgt_grp] = 1'b1;
                     end
                  end
                  OP_NV_ERASE: begin
                     next_s.done = 1'b1;
                     if (s.freeze) begin
                        next_s.refused = 1'b1;
                     end else begin
                        next_s.nv = '0;
                        if (s.wear < WEAR_LIMIT) begin
                           next_s.wear = s.wear + 7'h01;
                        end
                     end
                  end
                  OP_VOL: begin
                     next_s.vol[tgt_blk] = s.data[0];
                     next_s.done         = 1'b1;
                  end
                  OP_FREEZE: begin
                     next_s.freeze = 1'b1;
                     next_s.done   = 1'b1;
                  end
                  OP_FUSE_PER: begin
                     // Password fuse bars persistent fuse
                     next_s.done = 1'b1;
                     if (s.fuse_pw) begin
                        next_s.refused = 1'b1;
                     end else begin
                        next_s.fuse_per = 1'b1;
                     end
                  end
                  OP_FUSE_PW: begin
                     next_s.done = 1'b1;
                     if (s.fuse_per) begin
                        next_s.refused = 1'b1;
                     end else begin
                        next_s.fuse_pw = 1'b1;
                     end
                  end
                  OP_PW_LOAD: begin
                     next_s.done = 1'b1;
                     if (s.fuse_pw) begin
                        next_s.refused = 1'b1;
                     end else begin
                        next_s.pw[{s.data[1:0], 4'h0} +: 16] =
                           bus.wdata[31:16];
                     end
                  end
                  OP_PW_READ: begin
                     next_s.done = 1'b1;
                     if (s.fuse_pw) begin
                        next_s.refused = 1'b1;
                        next_s.pw_rd   = 16'h0000;
                     end else begin
                        next_s.pw_rd =
                           s.pw[{s.data[1:0], 4'h0} +: 16];
                     end
                  end
                  OP_PW_CAND: begin
                     // Candidate word for unlock
                     next_s.cand[{s.data[1:0], 4'h0} +: 16] =
                        bus.wdata[31:16];
                     next_s.done = 1'b1;
                  end
                  OP_UNLOCK: begin
                     if (!s.fuse_pw) begin
                        next_s.refused = 1'b1;
                        next_s.done    = 1'b1;
                     end else begin
                        next_s.cnt = PW_CNT;
                        next_s.st  = S_CHECK;
                     end
                  end
                  OP_VERIFY: begin
                     next_s.verify = {s.freeze, s.nv[tgt_grp],
                                      s.vol[tgt_blk]};
                     next_s.done   = 1'b1;
                  end
                  default: begin
                     // Unknown opcode refused
                     next_s.refused = 1'b1;
                     next_s.done    = 1'b1;
                  end
               endcase
            end
         end
         S_POLL: begin
            // Status polling, contents untouched
            if (s.cnt == '0) begin
               // Delay over, back to read mode
               next_s.done = 1'b1;
               next_s.st   = S_IDLE;
            end else begin
               // One cycle less to wait
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         S_ARRAY: begin
            // Wait for the array to finish
            if (arr_done) begin
               next_s.done = 1'b1;
               next_s.st   = S_IDLE;
            end
         end
         S_CHECK: begin
            // Compare only once the delay has run out
            if (s.cnt == '0) begin
               next_s.done = 1'b1;
               next_s.st   = S_IDLE;
               if (s.cand == s.pw) begin
                  next_s.freeze = FREEZE_OPEN;
               end else begin
                  next_s.refused = 1'b1;
               end
            end else begin
               // Delay still running
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         default: begin
            // Stray state code falls back to idle
            next_s.st = S_IDLE;
         end
      endcase

      // Registered read data, zero outside the answer cycle
      next_s.rd_data = 32'h0000_0000;
      if (bus.rd) begin
         case (bus.addr)
            REG_CMD: begin
               // Status flags
               next_s.rd_data[ST_BUSY] = (s.st != S_IDLE);
               next_s.rd_data[ST_DONE] = s.done;
               next_s.rd_data[ST_REF]  = s.refused;
               next_s.rd_data[ST_FRZ]  = s.freeze;
               next_s.rd_data[ST_FPER] = s.fuse_per;
               next_s.rd_data[ST_FPW]  = s.fuse_pw;
               next_s.rd_data[ST_WEAR] = (s.wear >= WEAR_LIMIT);
               next_s.rd_data[ST_PIN]  = s.wp_sync;
            end
            REG_TARGET: begin
               next_s.rd_data[8:0] = s.target;
            end
            REG_DATA: begin
               next_s.rd_data[15:0] = s.data;
            end
            REG_VERIFY: begin
               next_s.rd_data[2:0] = s.verify;
            end
            REG_PWRD: begin
               next_s.rd_data[15:0] = s.pw_rd;
            end
            REG_WEAR: begin
               next_s.rd_data[6:0] = s.wear;
            end
            default: begin
               // Unmapped reads return zero
               next_s.rd_data = 32'h0000_0000;
            end
         endcase
      end

      // Hardware reset: volatile state only
      if (rst) begin
         next_s.st      = S_IDLE;
         next_s.cnt     = '0;
         next_s.vol     = '0;
         next_s.freeze  = s.fuse_pw ? FREEZE_LOCKED : FREEZE_OPEN;
         next_s.cand    = '0;
         next_s.target  = 9'h000;
         next_s.data    = 16'h0000;
         next_s.refused = 1'b0;
         next_s.done    = 1'b0;
         next_s.verify  = 3'h0;
         next_s.pw_rd   = 16'h0000;
         next_s.rd_data = 32'h0000_0000;
         next_s.arr     = '0;
      end

      if (nv_init) begin
         // Wins over reset for the freeze flag
         next_s.nv       = '0;
         next_s.fuse_per = 1'b0;
         next_s.fuse_pw  = 1'b0;
         next_s.pw       = '0;
         next_s.wear     = 7'h00;
         next_s.freeze   = FREEZE_OPEN;
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      // Reset is folded into next_s
      s <= next_s;
   end

   // Outputs
   assign rd_data = s.rd_data;
   assign arr     = s.arr;
   // Busy straight from the state flops
   assign busy    = (s.st != S_IDLE);

endmodule : fbpl_core

// [core/fbpl_pkg.sv]
// Constants, types and state layout of the block protection logic
// Function
// - One persistent guard bit per group
// - Erase all guard bits; host preprograms first
// - Freeze flag set makes guard bits fixed
// - Persistent scheme: reset clears, no command clears
// - Volatile guard per block, zero after reset
// - Protected is OR of both guards
// - Volatile write sets or clears, unlimited
// - Guard bits persist; erase rated 100 cycles
// - Freeze rejects guard program and erase
// - Low pin locks four outer boot blocks
// - Protected program: poll 1us, no change
// - Protected erase: poll 50us, no change
// - Verify returns volatile, persistent, freeze
// - Persistent fuse blocks password fuse
// - Password scheme: reset forces freeze locked
// - Password match clears freeze, else nothing
// - Each password check waits 2us
// - Password fuse hides and fixes password
// - Unlock ignored in persistent scheme
// - Freeze set command sets freeze flag
package fbpl_pkg;

   // Clock and timing
   localparam int CLK_MHZ       = 10;
   localparam int POLL_PROG_US  = 1;
   localparam int POLL_ERASE_US = 50;
   localparam int PW_CHECK_US   = 2;
   localparam int CNT_W         = 9;
   localparam logic [CNT_W-1:0] PROG_CNT =
      CNT_W'(POLL_PROG_US * CLK_MHZ - 1);
   localparam logic [CNT_W-1:0] ERASE_CNT =
      CNT_W'(POLL_ERASE_US * CLK_MHZ - 1);
   localparam logic [CNT_W-1:0] PW_CNT =
      CNT_W'(PW_CHECK_US * CLK_MHZ - 1);

   // Array geometry
   localparam int NUM_BLOCKS = 78;
   localparam int NV_GROUPS  = 36;
   localparam int PW_W       = 64;
   localparam logic [6:0] WEAR_LIMIT = 7'h64;

   // Register offsets
   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_TARGET = 8'h04;
   localparam logic [7:0] REG_DATA   = 8'h08;
   localparam logic [7:0] REG_VERIFY = 8'h0C;
   localparam logic [7:0] REG_PWRD   = 8'h10;
   localparam logic [7:0] REG_WEAR   = 8'h14;

   // Status field positions (read at REG_CMD)
   localparam int ST_BUSY  = 0;
   localparam int ST_DONE  = 1;
   localparam int ST_REF   = 2;
   localparam int ST_FRZ   = 3;
   localparam int ST_FPER  = 4;
   localparam int ST_FPW   = 5;
   localparam int ST_WEAR  = 6;
   localparam int ST_PIN   = 7;

   // Reset values
   localparam logic FREEZE_OPEN   = 1'b0;
   localparam logic FREEZE_LOCKED = 1'b1;

   // Command opcodes
   localparam logic [3:0] OP_PROG     = 4'h1;
   localparam logic [3:0] OP_ERASE    = 4'h2;
   localparam logic [3:0] OP_NV_SET   = 4'h3;
   localparam logic [3:0] OP_NV_ERASE = 4'h4;
   localparam logic [3:0] OP_VOL      = 4'h5;
   localparam logic [3:0] OP_FREEZE   = 4'h6;
   localparam logic [3:0] OP_FUSE_PER = 4'h7;
   localparam logic [3:0] OP_FUSE_PW  = 4'h8;
   localparam logic [3:0] OP_PW_LOAD  = 4'h9;
   localparam logic [3:0] OP_PW_READ  = 4'hA;
   localparam logic [3:0] OP_PW_CAND  = 4'hB;
   localparam logic [3:0] OP_UNLOCK   = 4'hC;
   localparam logic [3:0] OP_VERIFY   = 4'hD;

   // Engine states
   typedef enum logic [3:0] {
      S_IDLE  = 4'h1,
      S_POLL  = 4'h2,
      S_ARRAY = 4'h4,
      S_CHECK = 4'h8
   } fbpl_state_e;

   // Register bus request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } fbpl_bus_s;

   // Request toward the array engine
   typedef struct packed {
      logic       req;
      logic       erase;
      logic [8:0] sector;
   } fbpl_arr_s;

   // Whole state of the core
   typedef struct packed {
      fbpl_state_e           st;
      logic [CNT_W-1:0]      cnt;
      logic [NV_GROUPS-1:0]  nv;
      logic [NUM_BLOCKS-1:0] vol;
      logic                  freeze;
      logic                  fuse_per;
      logic                  fuse_pw;
      logic [PW_W-1:0]       pw;
      logic [PW_W-1:0]       cand;
      logic [8:0]            target;
      logic [15:0]           data;
      logic                  refused;
      logic                  done;
      logic [2:0]            verify;
      logic [15:0]           pw_rd;
      logic [6:0]            wear;
      logic                  wp_meta;
      logic                  wp_sync;
      logic [31:0]           rd_data;
      fbpl_arr_s             arr;
   } fbpl_core_s;

endpackage : fbpl_pkg

// [test/fbpl_arr_model.sv]
// Behavioural array engine answering program and erase requests
`timescale 1ns/1ns
module fbpl_arr_model
   import fbpl_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // Request and answer delay
   input  wire fbpl_arr_s   arr,
   input  wire logic [3:0]  dly,
   // Answer and request count
   output      logic        arr_done,
   output      logic [15:0] n_req
);
   logic [3:0] left;   // Cycles until the answer
   // Counts requests, answers after dly cycles
   always_ff @(posedge mclk) begin
      arr_done <= 1'b0;
      if (rst) begin
         left  <= 4'h0;
         n_req <= 16'h0000;
      end else if (arr.req) begin
         left  <= dly;
         n_req <= n_req + 16'h0001;
      end else if (left == 4'h1) begin
         arr_done <= 1'b1;
         left     <= 4'h0;
      end else if (left > 4'h1) begin
         left <= left - 4'h1;
      end
   end
endmodule : fbpl_arr_model

// [test/fbpl_core_props.sv]
// Concurrent checks on the ports of the protection core
`timescale 1ns/1ns
module fbpl_core_props
   import fbpl_pkg::*;
(
   // Clock and resets
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        nv_init,
   // Register port
   input wire fbpl_bus_s   bus,
   input wire logic [31:0] rd_data,
   // Pin and array side
   input wire logic        boot_guard_pin_n,
   input wire fbpl_arr_s   arr,
   input wire logic        arr_done,
   input wire logic        busy
);
   logic [9:0] bcnt;   // Cycles of the current busy run
   logic       seen;   // Busy run that went to the array
   // Measures each busy run
   always_ff @(posedge mclk) begin
      if (rst || !busy) begin
         bcnt <= 10'h000;
         seen <= 1'b0;
      end else begin
         bcnt <= bcnt + 10'h001;
         seen <= seen | arr.req;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   property p_rd_idle;
      !$past(bus.rd) |-> rd_data == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_unmapped;
      $past(bus.rd) && $past(bus.addr) == 8'h20 |-> rd_data == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_stat_busy;
      $past(bus.rd) && $past(bus.addr) == REG_CMD
         |-> rd_data[ST_BUSY] == $past(busy);
   endproperty
   a_stat_busy: assert property (p_stat_busy) else $error("status busy");
   property p_req_pulse;
      arr.req |=> !arr.req;
   endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("long request");
   property p_req_cause;
      arr.req |-> busy && $past(bus.wr) && $past(bus.addr) == REG_CMD;
   endproperty
   a_req_cause: assert property (p_req_cause) else $error("stray request");
   property p_hold_tgt;
      busy && $past(busy) && !arr.req |-> $stable(arr.sector)
         && $stable(arr.erase);
   endproperty
   a_hold_tgt: assert property (p_hold_tgt) else $error("target moved");
   property p_poll_len;
      !$past(rst) && $fell(busy) && !seen |-> bcnt == 10'h00A
         || bcnt == 10'h014 || bcnt == 10'h1F4;
   endproperty
   a_poll_len: assert property (p_poll_len) else $error("poll length");
   property p_outer_pin;
      arr.req && arr.sector inside {9'h000, 9'h001, 9'h1FE, 9'h1FF}
         |-> $past(boot_guard_pin_n, 2) || $past(boot_guard_pin_n, 3)
         || $past(boot_guard_pin_n, 4);
   endproperty
   a_outer_pin: assert property (p_outer_pin) else $error("pin ignored");
endmodule : fbpl_core_props
bind fbpl_core fbpl_core_props fbpl_core_props_inst (.mclk(mclk), .rst(rst),
   .nv_init(nv_init), .bus(bus), .rd_data(rd_data),
   .boot_guard_pin_n(boot_guard_pin_n), .arr(arr), .arr_done(arr_done),
   .busy(busy));

// [test/flash_block_protection_logic_tb.sv]
// Self-checking bench for the block protection core
`timescale 1ns/1ns
module flash_block_protection_logic_tb;
   import fbpl_pkg::*;
   logic        mclk    = 1'b0;   // Bench clock
   logic        rst     = 1'b1;   // Hardware reset
   logic        nv_init = 1'b1;   // Persistent state init
   logic        pin_n   = 1'b1;   // Boot guard pin
   fbpl_bus_s   bus     = '0;     // Register requests
   logic [3:0]  dly     = 4'h3;   // Array answer delay
   logic [31:0] rd_data;
   fbpl_arr_s   arr;
   logic        arr_done;
   logic        busy;
   logic [15:0] n_req;
   logic [31:0] v;                // Last read value
   logic [15:0] pw [4];           // Model password
   logic [15:0] cw;               // Candidate word
   int          exp_req = 0;      // Model request count
   int          cyc;              // Busy cycles of last command
   int          fails = 0;
   int          n_compared = 0;
   logic [8:0]  sec [6] = '{9'h000, 9'h001, 9'h00A, 9'h080, 9'h1FE, 9'h1FF};
   // Clock of 100 ns
   always #50 mclk = ~mclk;
   fbpl_core fbpl_core_inst (.mclk(mclk), .rst(rst), .nv_init(nv_init),
      .bus(bus), .rd_data(rd_data), .boot_guard_pin_n(pin_n), .arr(arr),
      .arr_done(arr_done), .busy(busy));
   fbpl_arr_model fbpl_arr_model_inst (.mclk(mclk), .rst(rst), .arr(arr),
      .dly(dly), .arr_done(arr_done), .n_req(n_req));
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic end_of_test();
      $display("Counts: %0d compared, %0d failed", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1 v = rd_data;
   endtask : rd
   // Command write, then bounded wait for idle
   task automatic cmd(input logic [3:0] op, input logic [15:0] w = 16'h0);
      wr(REG_CMD, {w, 12'h000, op});
      #1 cyc = 0;
      while (busy !== 1'b0 && cyc < 3000) begin
         @(posedge mclk);
         #1 cyc++;
      end
      if (cyc >= 3000) begin
         fails++;
         end_of_test();
      end
   endtask : cmd
   task automatic at(input logic [8:0] s, input logic [3:0] op);
      wr(REG_TARGET, {23'h0, s});
      cmd(op);
   endtask : at
   task automatic vfy(input logic [8:0] s);
      at(s, OP_VERIFY);
      rd(REG_VERIFY);
   endtask : vfy
   task automatic pulse_rst(input logic init);
      @(posedge mclk);
      rst     <= 1'b1;
      nv_init <= init;
      @(posedge mclk);
      rst     <= 1'b0;
      nv_init <= 1'b0;
      exp_req = 0;
   endtask : pulse_rst
   initial begin
      v = $urandom(71326);
      repeat (2) @(posedge mclk);
      rst     <= 1'b0;
      nv_init <= 1'b0;
      vfy(9'h000);
      chk("verify after init", v, 32'h0);
      rd(8'h20);
      chk("unmapped read", v, 32'h0);
      $display("Test reset values done");
      // Volatile guard toggled on inner and outer blocks
      foreach (sec[j]) begin
         dly <= 4'(1 + $urandom_range(7));
         wr(REG_DATA, 32'h1);
         at(sec[j], OP_VOL);
         vfy(sec[j]);
         chk("vol set", v, 32'h1);
         at(sec[j], OP_PROG);
         chk("prog poll", cyc, POLL_PROG_US * CLK_MHZ);
         chk("prog guarded", n_req, exp_req);
         wr(REG_DATA, 32'h0);
         at(sec[j], OP_VOL);
         at(sec[j], OP_PROG);
         exp_req++;
         chk("prog open", n_req, exp_req);
         chk("array sector", arr.sector, sec[j]);
      end
      wr(REG_DATA, 32'h1);
      at(9'h080, OP_VOL);
      at(9'h080, OP_ERASE);
      chk("erase poll", cyc, POLL_ERASE_US * CLK_MHZ);
      chk("erase guarded", n_req, exp_req);
      $display("Test volatile guard done");
      at(9'h020, OP_NV_SET);
      vfy(9'h038);
      chk("group shares guard", v, 32'h2);
      vfy(9'h040);
      chk("next group clear", v, 32'h0);
      at(9'h001, OP_NV_SET);
      vfy(9'h000);
      chk("boot block own guard", v, 32'h0);
      at(9'h03F, OP_PROG);
      chk("nv guarded prog", n_req, exp_req);
      // Preprogram every guard before the group erase
      for (int k = 0; k < 512; k++) begin
         at(9'(k), OP_NV_SET);
      end
      at(9'h000, OP_NV_ERASE);
      vfy(9'h020);
      chk("guards erased", v, 32'h0);
      rd(REG_WEAR);
      chk("wear count", v, 32'h1);
      repeat (99) cmd(OP_NV_ERASE);
      rd(REG_CMD);
      chk("wear flag", v[ST_WEAR], 1'b1);
      cmd(4'hF);
      rd(REG_CMD);
      chk("bad opcode", v[ST_REF:ST_DONE], 2'h3);
      at(9'h040, OP_NV_SET);
      $display("Test persistent guard done");
      at(9'h040, OP_FREEZE);
      rd(REG_CMD);
      chk("freeze set", v[ST_FRZ], 1'b1);
      at(9'h060, OP_NV_SET);
      rd(REG_CMD);
      chk("nv set refused", v[ST_REF], 1'b1);
      at(9'h040, OP_NV_ERASE);
      vfy(9'h040);
      chk("guards frozen", v, 32'h6);
      vfy(9'h060);
      chk("no new guard", v, 32'h4);
      cmd(OP_UNLOCK);
      rd(REG_CMD);
      chk("unlock ignored", v[ST_FRZ], 1'b1);
      pulse_rst(1'b0);
      vfy(9'h040);
      chk("reset keeps guard", v, 32'h2);
      vfy(9'h080);
      chk("reset clears vol", v, 32'h0);
      $display("Test freeze done");
      pin_n <= 1'b0;
      repeat (4) @(posedge mclk);
      rd(REG_CMD);
      chk("pin level", v[ST_PIN], 1'b0);
      foreach (sec[j]) begin
         at(sec[j], OP_PROG);
         if (j != 2 && j != 3) begin
            chk("pin blocks", n_req, exp_req);
         end else begin
            exp_req++;
            chk("pin spares inner", n_req, exp_req);
         end
      end
      pin_n <= 1'b1;
      repeat (4) @(posedge mclk);
      at(9'h1FF, OP_ERASE);
      exp_req++;
      chk("pin released", n_req, exp_req);
      chk("erase kind", arr.erase, 1'b1);
      $display("Test boot pin done");
      cmd(OP_FUSE_PER);
      cmd(OP_FUSE_PW);
      rd(REG_CMD);
      chk("pw fuse barred", v[ST_FPW:ST_REF], 4'h5);
      pulse_rst(1'b1);
      for (int i = 0; i < 4; i++) begin
         pw[i] = 16'($urandom);
         wr(REG_DATA, i);
         cmd(OP_PW_LOAD, pw[i]);
      end
      wr(REG_DATA, 32'h2);
      cmd(OP_PW_READ);
      rd(REG_PWRD);
      chk("pw readback", v, {16'h0, pw[2]});
      cmd(OP_FUSE_PW);
      cmd(OP_PW_LOAD, ~pw[2]);
      cmd(OP_PW_READ);
      rd(REG_PWRD);
      chk("pw hidden", v, 32'h0);
      pulse_rst(1'b0);
      rd(REG_CMD);
      chk("locked after reset", v[ST_FRZ], 1'b1);
      // Last word wrong first, then all words right
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 4; i++) begin
            cw = pw[i] ^ ((k == 0 && i == 3) ? 16'h0001 : 16'h0000);
            wr(REG_DATA, i);
            cmd(OP_PW_CAND, cw);
         end
         cmd(OP_UNLOCK);
         chk("check delay", cyc, PW_CHECK_US * CLK_MHZ);
         rd(REG_CMD);
         chk("freeze after unlock", v[ST_FRZ], k == 0);
      end
      $display("Test password done");
      end_of_test();
   end
endmodule : flash_block_protection_logic_tb
